// >>> rtl/ppmux_pkg.sv
// Purpose: Shared constants and carriers for the parallel port mode mux
// Assumes: One clock, core_clk at 100 MHz
// Notes:   Pin groups travel as packed structs
package ppmux_pkg;

  // ******************************************************************
  // Widths and reset values
  // ******************************************************************
  localparam int unsigned PPMUX_ADDR_W   = 18;
  localparam int unsigned PPMUX_DATA_W   = 16;
  localparam logic [17:0] PPMUX_ADDR_RST = 18'h0_0000;
  localparam logic [15:0] PPMUX_DATA_RST = 16'h0000;
  localparam logic        PPMUX_OE_RST   = 1'b1;
  localparam logic        PPMUX_KEEP_RST = 1'b0;
  localparam int unsigned PPMUX_SYNC_CYC = 2;

  // ******************************************************************
  // Carriers
  // ******************************************************************
  typedef struct packed {
    logic        access;
    logic        write;
    logic [17:0] addr;
    logic [15:0] wdata;
  } ppmux_external_memory_mode_req_type;

  typedef struct packed {
    logic        drive;
    logic [15:0] rdata;
  } ppmux_host_rsp_type;

  typedef struct packed {
    logic [17:0] addr;
    logic [15:0] data;
  } ppmux_pin_in_type;

endpackage

// >>> rtl/ppmux_top.sv
// Purpose: Shares the parallel port address and data pins between the
//          external memory interface and the host port
// Assumes: Pin inputs are asynchronous; external_memory_mode and host port logic run on
//          core_clk; keeper_enable_bit comes from the bank switch
//          control register bit held elsewhere on this clock
// Notes:   Output enables are active low; the keeper is reported on a
//          separate flag so the pad model can apply a weak hold
//
// How it works
// - Mode high: device drives address pins
// - Mode low: address pins are host inputs
// - External mode: data driven on writes, sampled
// - Host mode: host port logic drives data
// - Float low: address pins high impedance
// - Float low: data pins high impedance
// - Keeper holds last driven data level
// - Keeper off at reset, software controlled
module ppmux_top
  import ppmux_pkg::*;
(
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               nrst,
  // Mode and float pins
  input  wire logic               port_mode_select,
  input  wire logic               float_ctrl_n,
  // Keeper enable from control register
  input  wire logic               keeper_enable_bit,
  // External memory interface side
  input  wire ppmux_external_memory_mode_req_type external_memory_mode_req,
  output logic [15:0]             external_memory_mode_rdata,
  // Host port side
  input  wire ppmux_host_rsp_type host_rsp,
  output ppmux_pin_in_type        host_pins,
  output logic                    host_port_mode,
  // Address pins
  input  wire logic [17:0]        parallel_port_address_in,
  output logic [17:0]             parallel_port_address_out,
  output logic                    parallel_port_address_oe_n,
  // Data pins
  input  wire logic [15:0]        parallel_port_data_in,
  output logic [15:0]             parallel_port_data_out,
  output logic                    parallel_port_data_oe_n,
  output logic                    data_keeper_active
);

  // ******************************************************************
  // Reset release and pin synchronisers
  // ******************************************************************
  logic        rst_meta_ff;
  logic        rst_n_ff;
  logic [1:0]  mode_sync_ff;
  logic [1:0]  float_sync_ff;
  logic [17:0] addr_meta_ff;
  logic [17:0] addr_sync_ff;
  logic [15:0] data_meta_ff;
  logic [15:0] data_sync_ff;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // Float starts asserted so nothing drives until the pins are seen
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      mode_sync_ff  <= 2'h0;
      float_sync_ff <= 2'h0;
      addr_meta_ff  <= PPMUX_ADDR_RST;
      addr_sync_ff  <= PPMUX_ADDR_RST;
      data_meta_ff  <= PPMUX_DATA_RST;
      data_sync_ff  <= PPMUX_DATA_RST;
    end else begin
      mode_sync_ff  <= {mode_sync_ff[0], port_mode_select};
      float_sync_ff <= {float_sync_ff[0], float_ctrl_n};
      addr_meta_ff  <= parallel_port_address_in;
      addr_sync_ff  <= addr_meta_ff;
      data_meta_ff  <= parallel_port_data_in;
      data_sync_ff  <= data_meta_ff;
    end
  end

  // ******************************************************************
  // Pin direction decode
  // ******************************************************************
  wire external_memory_mode = mode_sync_ff[1];
  wire host_port_mode_w     = ~mode_sync_ff[1];
  wire pins_enabled         = float_sync_ff[1];

  // Address only ever leaves in external mode; host mode never drives
  wire drive_addr = external_memory_mode & pins_enabled;
  wire external_memory_mode_write = external_memory_mode & external_memory_mode_req.access & external_memory_mode_req.write;
  wire host_read  = host_port_mode_w & host_rsp.drive;
  wire drive_data = (external_memory_mode_write | host_read) & pins_enabled;

  wire [17:0] nxt_addr_out = drive_addr ? external_memory_mode_req.addr : parallel_port_address_out;
  wire [15:0] nxt_data_sel = external_memory_mode_write ? external_memory_mode_req.wdata : host_rsp.rdata;
  // Holding the last value keeps the keeper level equal to the last drive
  wire [15:0] nxt_data_out = drive_data ? nxt_data_sel : parallel_port_data_out;
  wire        nxt_keep     = keeper_enable_bit & ~drive_data;

  // ******************************************************************
  // Registered pin and side outputs
  // ******************************************************************
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      parallel_port_address_out  <= PPMUX_ADDR_RST;
      parallel_port_address_oe_n <= PPMUX_OE_RST;
      parallel_port_data_out     <= PPMUX_DATA_RST;
      parallel_port_data_oe_n    <= PPMUX_OE_RST;
      data_keeper_active         <= PPMUX_KEEP_RST;
      external_memory_mode_rdata                 <= PPMUX_DATA_RST;
      host_pins                  <= '0;
      host_port_mode             <= 1'b0;
    end else begin
      parallel_port_address_out  <= nxt_addr_out;
      parallel_port_address_oe_n <= ~drive_addr;
      parallel_port_data_out     <= nxt_data_out;
      parallel_port_data_oe_n    <= ~drive_data;
      data_keeper_active         <= nxt_keep;
      external_memory_mode_rdata                 <= data_sync_ff;
      host_pins.addr             <= addr_sync_ff;
      host_pins.data             <= data_sync_ff;
      host_port_mode             <= host_port_mode_w;
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_ff);

  sequence s_float_low;
    !float_sync_ff[1];
  endsequence

  sequence s_host_mode;
    !mode_sync_ff[1];
  endsequence

  sequence s_data_release;
    !parallel_port_data_oe_n ##1 parallel_port_data_oe_n;
  endsequence

  a_addr_ext_drive: assert property (
    mode_sync_ff[1] && float_sync_ff[1] |=> !parallel_port_address_oe_n
      && parallel_port_address_out == $past(external_memory_mode_req.addr))
    else $error("address not driven in external mode");

  a_addr_host_in: assert property (
    s_host_mode |=> parallel_port_address_oe_n && host_port_mode)
    else $error("address pins not inputs in host mode");

  a_data_ext_write: assert property (
    mode_sync_ff[1] && float_sync_ff[1] && external_memory_mode_req.access && external_memory_mode_req.write
      |=> !parallel_port_data_oe_n && parallel_port_data_out == $past(external_memory_mode_req.wdata))
    else $error("external write data not driven");

  // Pin paths are compared only once three samples since reset exist;
  // before that the sync flops still hold their reset word
  a_data_ext_read: assert property (
    $past(rst_n_ff, 3)
      |-> external_memory_mode_rdata == $past(parallel_port_data_in, 3))
    else $error("read data not sampled");

  a_data_host_drive: assert property (
    !mode_sync_ff[1] && float_sync_ff[1] && host_rsp.drive
      |=> !parallel_port_data_oe_n && parallel_port_data_out == $past(host_rsp.rdata))
    else $error("host read data not driven");

  a_data_host_in: assert property (
    $past(rst_n_ff, 3)
      |-> host_pins.data == $past(parallel_port_data_in, 3))
    else $error("host data path latency wrong");

  a_addr_float: assert property (
    s_float_low |=> parallel_port_address_oe_n)
    else $error("address driven while floated");

  a_data_float: assert property (
    s_float_low |=> parallel_port_data_oe_n)
    else $error("data driven while floated");

  a_keeper_hold: assert property (
    s_data_release |-> parallel_port_data_out == $past(parallel_port_data_out))
    else $error("keeper level differs from last drive");

  // Released outputs must not move, or the keeper would hold a stale level
  a_data_held: assert property (
    parallel_port_data_oe_n |-> $stable(parallel_port_data_out))
    else $error("released data level moved");

  a_addr_held: assert property (
    parallel_port_address_oe_n |-> $stable(parallel_port_address_out))
    else $error("released address moved");

  a_mode_flag: assert property (
    host_port_mode |-> parallel_port_address_oe_n)
    else $error("address driven while host mode flagged");

  a_keeper_ctrl: assert property (
    ##1 data_keeper_active == ($past(keeper_enable_bit) && parallel_port_data_oe_n))
    else $error("keeper not following its enable");

  a_keeper_reset: assert property (
    $rose(rst_n_ff) |-> !data_keeper_active)
    else $error("keeper enabled out of reset");

  a_addr_never: assert property (
    s_host_mode ##1 s_host_mode |-> parallel_port_address_oe_n)
    else $error("address driven in host mode");

endmodule

// >>> dv/ppmux_partner.sv
// Purpose: Host processor or external memory at the far side of the pins
// Assumes: Bench decides when this side drives
// Notes:   Released pins show the inverse of the last value, never a copy
module ppmux_partner (
  // Clock
  input  wire logic        core_clk,
  // Drive request
  input  wire logic        en,
  input  wire logic [17:0] a,
  input  wire logic [15:0] d,
  // Pin values from this side
  output logic      [17:0] addr_pin,
  output logic      [15:0] data_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Known start word so released pins never read as unknown
  logic [17:0] last_a_ff = 18'h0_0000;
  logic [15:0] last_d_ff = 16'h0000;
  always @(posedge core_clk) begin
    if (en) begin
      last_a_ff <= a;
      last_d_ff <= d;
    end
  end
  // Far-side address and data words onto the pins
  assign addr_pin = en ? a : ~last_a_ff;
  assign data_pin = en ? d : ~last_d_ff;
endmodule

// >>> dv/ppmux_top_bench.sv
// Purpose: Self-checking bench for the parallel port mode mux
// Assumes: Inputs driven on the falling edge of core_clk
// Notes:   Waits cover the two sync flops plus the output flop
module ppmux_top_bench
  import ppmux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, nrst, mode, flt_n, keep_en, keeper, p_en;
  logic a_oe_n, d_oe_n, hmode;
  logic [17:0] a_out, p_a, p_apin, a_bus, a;
  logic [15:0] d_out, p_d, p_dpin, d_bus, rdata, d;
  ppmux_external_memory_mode_req_type req;
  ppmux_host_rsp_type rsp;
  ppmux_pin_in_type   hpins;
  int miscompares, tests_run;
  logic k;
  assign a_bus = !a_oe_n ? a_out : p_apin;
  // Partner overpowers the weak keeper
  assign d_bus = !d_oe_n ? d_out : (p_en || !keeper) ? p_dpin : d_out;
  ppmux_top dut (.core_clk(core_clk), .nrst(nrst), .port_mode_select(mode),
    .float_ctrl_n(flt_n), .keeper_enable_bit(keep_en), .external_memory_mode_req(req),
    .external_memory_mode_rdata(rdata), .host_rsp(rsp), .host_pins(hpins), .host_port_mode(hmode),
    .parallel_port_address_in(a_bus), .parallel_port_address_out(a_out),
    .parallel_port_address_oe_n(a_oe_n), .parallel_port_data_in(d_bus),
    .parallel_port_data_out(d_out), .parallel_port_data_oe_n(d_oe_n),
    .data_keeper_active(keeper));
  ppmux_partner far (.core_clk(core_clk), .en(p_en), .a(p_a), .d(p_d),
    .addr_pin(p_apin), .data_pin(p_dpin));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [1:0] exp_oe_n(input logic ext, input logic flt_hi, input logic wr);
    return {~(ext & flt_hi), ~(flt_hi & wr)};
  endfunction
  task automatic end_of_test;
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200us;
    miscompares++;
    end_of_test;
  end
  initial begin
    {nrst, keep_en, p_en, p_a, p_d} = '0;
    {mode, flt_n} = 2'b11;
    req = '0;
    rsp = '0;
    void'($urandom(86014));
    cyc(3);
    nrst = 1'b1;
    cyc(8);
    chk({a_oe_n, keeper, hmode}, 3'b000);
    for (int i = 0; i < 8; i++) begin
      a = 18'($urandom);
      d = 16'($urandom);
      k = (i == 0) ? 1'b1 : 1'($urandom);
      keep_en = k;
      req = '{1'b1, 1'b1, a, d};
      cyc(2);
      chk({d_oe_n, a_out, d_out}, {1'b0, a, d});
      req.access = 1'b0;
      cyc(2);
      chk({d_oe_n, keeper, d_out}, {1'b1, k, d});
      if (k) chk(d_bus, d);
    end
    p_en = 1'b1;
    p_d = 16'($urandom);
    cyc(4);
    chk(rdata, p_d);
    p_en = 1'b0;
    for (int m = 0; m < 2; m++) begin
      mode = 1'(m);
      flt_n = 1'b0;
      req = '{1'b1, 1'b1, a, d};
      rsp = '{1'b1, d};
      cyc(5);
      chk({a_oe_n, d_oe_n}, exp_oe_n(1'(m), 1'b0, 1'b1));
    end
    rsp = '0;
    flt_n = 1'b1;
    mode = 1'b0;
    p_en = 1'b1;
    p_a = 18'($urandom);
    p_d = 16'($urandom);
    cyc(5);
    chk({hmode, a_oe_n, d_oe_n}, {1'b1, exp_oe_n(1'b0, 1'b1, 1'b0)});
    chk(hpins, {p_a, p_d});
    p_en = 1'b0;
    rsp = '{1'b1, ~d};
    cyc(2);
    chk({d_oe_n, d_out}, {1'b0, ~d});
    rsp.drive = 1'b0;
    cyc(2);
    chk(d_oe_n, 1'b1);
    keep_en = 1'b1;
    cyc(2);
    chk(keeper, 1'b1);
    // Control register clears with the device, so the enable drops too
    nrst = 1'b0;
    keep_en = 1'b0;
    cyc(1);
    chk({keeper, a_oe_n, d_oe_n}, 3'b011);
    nrst = 1'b1;
    cyc(8);
    chk({hmode, keeper, a_oe_n}, 3'b101);
    keep_en = 1'b1;
    cyc(2);
    chk(keeper, 1'b1);
    end_of_test;
  end
endmodule
